// ===== irqspr_defs.svh
// irqspr_defs.svh: offsets, field positions, reset values and counts for the
// interrupt status / proximity reload block.
// assumes: included by bare name from the block's package and design files.
`ifndef IRQSPR_DEFS_SVH
`define IRQSPR_DEFS_SVH

`define IRQSPR_ADDR_W         4
`define IRQSPR_OFS_STATUS     4'h0
`define IRQSPR_OFS_RELOAD     4'h4
`define IRQSPR_OFS_CONFIG     4'h8
`define IRQSPR_OFS_PRIO_LO    4'hc

`define IRQSPR_NSRC           8
`define IRQSPR_NSRC_LOG       3
`define IRQSPR_VEC_W          6
`define IRQSPR_PRIO_W         3
`define IRQSPR_VEC_MSB        5
`define IRQSPR_PRIO_LSB       8
`define IRQSPR_PRIO_MSB       10

`define IRQSPR_CFG_MVEC_BIT   0
`define IRQSPR_CFG_PTEN_BIT   1
`define IRQSPR_PRIO_NONE      3'h0
`define IRQSPR_RELOAD_RST     32'h0000_0000
`define IRQSPR_WORD_ZERO      32'h0000_0000
`define IRQSPR_CNT_ONE        32'h0000_0001
`define IRQSPR_VEC_BASE       6'h00

`endif

// ===== irqspr_pkg.sv
// irqspr_pkg.sv: types shared by the block's design files.
// assumes: irqspr_defs.svh is on the include path.
`include "irqspr_defs.svh"

package irqspr_pkg;
    // one request presented to the core
    typedef struct packed {
        logic                        valid;
        logic [`IRQSPR_PRIO_W-1:0]   prio;
        logic [`IRQSPR_VEC_W-1:0]    vec;
    } irqspr_req_s;

    // register port from software
    typedef struct packed {
        logic [`IRQSPR_ADDR_W-1:0]   addr;
        logic [31:0]                 wdata;
        logic                        wr;
        logic                        rd;
    } irqspr_bus_s;

    typedef enum logic [0:0] {
        IRQSPR_PT_IDLE,
        IRQSPR_PT_COUNT
    } irqspr_pt_e;
endpackage : irqspr_pkg

// ===== irqspr_arbiter.sv
// irqspr_arbiter.sv: picks the highest-priority pending source.
// assumes: pending and priority inputs come from the same clock domain.
`timescale 1ns/1ps
`include "irqspr_defs.svh"

module irqspr_arbiter (
    // pending sources and their levels
    input  wire logic [`IRQSPR_NSRC-1:0]                  i_pend,
    input  wire logic [`IRQSPR_NSRC*`IRQSPR_PRIO_W-1:0]   i_prio,
    // winner
    output irqspr_pkg::irqspr_req_s                       o_win
);
    import irqspr_pkg::*;

    irqspr_req_s stage [0:`IRQSPR_NSRC];

    assign stage[0] = '0;

    // lowest index wins a tie; level zero means the source is disabled
    genvar g;
    generate
        for (g = 0; g < `IRQSPR_NSRC; g++) begin : g_src
            wire logic [`IRQSPR_PRIO_W-1:0] lvl = i_prio[g*`IRQSPR_PRIO_W +: `IRQSPR_PRIO_W];
            wire logic take = i_pend[g] && (lvl != `IRQSPR_PRIO_NONE)
                              && (!stage[g].valid || lvl > stage[g].prio);
            assign stage[g+1] = take ? irqspr_req_s'{valid: 1'b1, prio: lvl,
                                                     vec: `IRQSPR_VEC_BASE + 6'(g)}
                                     : stage[g];
        end
    endgenerate

    assign o_win = stage[`IRQSPR_NSRC];
endmodule : irqspr_arbiter

// ===== irqspr_top.sv
// irqspr_top.sv: interrupt status report and proximity reload slice.
// assumes: sources are synchronous to i_sys_clk; core takes o_core_req level.
`timescale 1ns/1ps
`include "irqspr_defs.svh"

module irqspr_top (
    // clock and reset
    input  wire logic                                     i_sys_clk,
    input  wire logic                                     i_sys_rst,
    // register port
    input  wire logic [`IRQSPR_ADDR_W-1:0]                i_addr,
    input  wire logic [31:0]                              i_wdata,
    input  wire logic                                     i_wr,
    input  wire logic                                     i_rd,
    output logic [31:0]                                   o_rdata,
    // interrupt sources
    input  wire logic [`IRQSPR_NSRC-1:0]                  i_src_pend,
    // core side
    output logic                                          o_core_req,
    output logic [`IRQSPR_VEC_W-1:0]                      o_core_vec,
    output logic [`IRQSPR_PRIO_W-1:0]                     o_core_prio,
    output logic                                          o_core_mvec
);
    import irqspr_pkg::*;

    logic [31:0]                             reload;
    logic [31:0]                             count;
    logic                                    mvec;
    logic                                    pt_en;
    logic [`IRQSPR_NSRC*`IRQSPR_PRIO_W-1:0]  prio_cfg;
    irqspr_pt_e                              pt_state;
    irqspr_req_s                             presented;
    irqspr_req_s                             win;
    irqspr_req_s                             last_win;

    // register decode
    wire logic wr_reload = i_wr && (i_addr == `IRQSPR_OFS_RELOAD);
    wire logic wr_config = i_wr && (i_addr == `IRQSPR_OFS_CONFIG);
    wire logic wr_prio   = i_wr && (i_addr == `IRQSPR_OFS_PRIO_LO);

    irqspr_arbiter u_arb (
        .i_pend (i_src_pend),
        .i_prio (prio_cfg),
        .o_win  (win)
    );

    // timer trigger: new or changed winning event while timer enabled
    wire logic new_event = win.valid && (win != last_win);
    wire logic trigger   = pt_en && new_event;
    wire logic expired   = (pt_state == IRQSPR_PT_COUNT) && (count == `IRQSPR_CNT_ONE);
    // a zero reload never starts the timer, so it never holds a request back
    wire logic start     = trigger && (pt_state == IRQSPR_PT_IDLE)
                           && (reload != `IRQSPR_WORD_ZERO);
    // hold presentation while the timer runs; rewriting the reload mid-count
    // does not cut the wait short, only disabling the timer does
    wire logic deferring = start || ((pt_state == IRQSPR_PT_COUNT) && pt_en && !expired);

    // status word: only the two fields, everything else zero
    wire logic [31:0] status_word = {21'h000000,
                                     presented.prio,
                                     2'h0,
                                     presented.vec};

    wire logic [31:0] next_rdata =
        !i_rd                               ? `IRQSPR_WORD_ZERO :
        (i_addr == `IRQSPR_OFS_STATUS)      ? status_word :
        (i_addr == `IRQSPR_OFS_RELOAD)      ? reload :
        (i_addr == `IRQSPR_OFS_CONFIG)      ? {30'h0, pt_en, mvec} :
        (i_addr == `IRQSPR_OFS_PRIO_LO)     ? {8'h00, prio_cfg} :
                                              `IRQSPR_WORD_ZERO;

    // software registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            reload   <= `IRQSPR_RELOAD_RST;
            mvec     <= 1'b0;
            pt_en    <= 1'b0;
            prio_cfg <= '0;
            o_rdata  <= `IRQSPR_WORD_ZERO;
        end else begin
            if (wr_reload) reload <= i_wdata;
            if (wr_config) begin
                mvec  <= i_wdata[`IRQSPR_CFG_MVEC_BIT];
                pt_en <= i_wdata[`IRQSPR_CFG_PTEN_BIT];
            end
            if (wr_prio) prio_cfg <= i_wdata[`IRQSPR_NSRC*`IRQSPR_PRIO_W-1:0];
            o_rdata <= next_rdata;
        end
    end

    // proximity timer: reload on trigger, count down, release on expiry
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pt_state <= IRQSPR_PT_IDLE;
            count    <= `IRQSPR_WORD_ZERO;
            last_win <= '0;
        end else begin
            last_win <= win;
            unique case (pt_state)
                IRQSPR_PT_IDLE: begin
                    if (start) begin
                        count    <= reload;
                        pt_state <= IRQSPR_PT_COUNT;
                    end
                end
                IRQSPR_PT_COUNT: begin
                    if (expired || !pt_en) begin
                        pt_state <= IRQSPR_PT_IDLE;
                        count    <= `IRQSPR_WORD_ZERO;
                    end else begin
                        count    <= count - `IRQSPR_CNT_ONE;
                    end
                end
            endcase
        end
    end

    // presentation to the core, held back while the timer runs
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            presented   <= '0;
            o_core_req  <= 1'b0;
            o_core_vec  <= '0;
            o_core_prio <= '0;
            o_core_mvec <= 1'b0;
        end else begin
            o_core_mvec <= mvec;
            if (win.valid && !deferring) begin
                presented   <= win;
                o_core_req  <= 1'b1;
                o_core_vec  <= win.vec;
                o_core_prio <= win.prio;
            end else if (!win.valid) begin
                o_core_req  <= 1'b0;
            end
        end
    end

    // helper: a software read strobe addressed to the status word
    sequence s_status_read;
        i_rd && (i_addr == `IRQSPR_OFS_STATUS);
    endsequence

    // timer steps: the reload is taken, then the count reaches its end
    sequence s_timer_start;
        start;
    endsequence

    sequence s_timer_expire;
        expired && win.valid;
    endsequence

    AST_STATUS_PRIO: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_status_read |=> o_rdata[`IRQSPR_PRIO_MSB:`IRQSPR_PRIO_LSB] == $past(presented.prio))
        else $error("status priority field mismatch");

    AST_STATUS_VEC: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_status_read |=> o_rdata[`IRQSPR_VEC_MSB:0] == $past(presented.vec))
        else $error("status vector field mismatch");

    AST_STATUS_ZERO: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_status_read |=> (o_rdata[31:11] == 21'h0) && (o_rdata[7:6] == 2'h0))
        else $error("status reserved bits not zero");

    AST_RELOAD_RW: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        wr_reload ##1 (i_rd && i_addr == `IRQSPR_OFS_RELOAD && !i_wr)
        |=> o_rdata == $past(i_wdata, 2))
        else $error("reload readback mismatch");

    AST_RELOAD_LOAD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_timer_start |=> (count == $past(reload)) && (pt_state == IRQSPR_PT_COUNT))
        else $error("timer not loaded from reload");

    AST_COUNT_DOWN: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (pt_state == IRQSPR_PT_COUNT && !expired && pt_en)
        |=> count == $past(count) - `IRQSPR_CNT_ONE)
        else $error("timer did not count down");

    AST_DEFER_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (pt_state == IRQSPR_PT_COUNT && !expired && pt_en && !o_core_req)
        |=> !o_core_req)
        else $error("request released while deferred");

    AST_MODE_OUT: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        wr_config |-> ##2 o_core_mvec == $past(i_wdata[`IRQSPR_CFG_MVEC_BIT], 2))
        else $error("mode not forwarded to core");

    AST_PRIO_ORDER: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (win.valid && !deferring) |=> o_core_prio == $past(win.prio))
        else $error("presented level is not the winner");

    AST_VEC_ORDER: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (win.valid && !deferring) |=> o_core_req && (o_core_vec == $past(win.vec)))
        else $error("presented vector is not the winner");

    // the request drops as soon as nothing is pending
    AST_IDLE_DROP: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !win.valid |=> !o_core_req)
        else $error("request kept with nothing pending");

    // expiry must hand the held winner to the core on the next edge
    AST_EXPIRE_RELEASE: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        s_timer_expire |=> o_core_req && (o_core_vec == $past(win.vec)))
        else $error("request not released at timer expiry");

    AST_TIMER_OFF: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !pt_en |=> pt_state == IRQSPR_PT_IDLE)
        else $error("timer runs while disabled");

    // register housekeeping: reset value and no change without a write
    AST_RELOAD_RESET: assert property (@(posedge i_sys_clk)
        i_sys_rst |=> reload == `IRQSPR_RELOAD_RST)
        else $error("reload not cleared by reset");

    AST_RELOAD_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !wr_reload |=> reload == $past(reload))
        else $error("reload changed without a write");

    AST_MODE_HOLD: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        !wr_config |=> mvec == $past(mvec))
        else $error("mode changed without a write");
endmodule : irqspr_top

// ===== irqspr_core_model.sv
// irqspr_core_model.sv: behavioural processor core that takes presented requests.
// assumes: fed by the core-side outputs of irqspr_top on the same clock.
`timescale 1ns/1ps
`include "irqspr_defs.svh"
module irqspr_core_model (
    // clock and reset
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_sys_rst,
    // presented request
    input  wire logic                       i_req,
    input  wire logic [`IRQSPR_VEC_W-1:0]   i_vector,
    input  wire logic [`IRQSPR_PRIO_W-1:0]  i_level,
    input  wire logic                       i_multi,
    // what the core took
    output logic [`IRQSPR_VEC_W-1:0]        o_taken_vector,
    output logic [`IRQSPR_PRIO_W-1:0]       o_taken_level
);
    logic req_d;
    // take vector and level on each new request, trusted in single-vector mode only
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            req_d          <= 1'b0;
            o_taken_vector <= '0;
            o_taken_level  <= '0;
        end else begin
            req_d <= i_req;
            if (i_req && !req_d && !i_multi) begin
                o_taken_vector <= i_vector;
                o_taken_level  <= i_level;
            end
        end
    end
endmodule : irqspr_core_model

// ===== tb.sv
// tb.sv: self-checking bench for the status report and proximity reload slice.
// assumes: irqspr_pkg, irqspr_top and irqspr_core_model are compiled first.
`timescale 1ns/1ps
`include "irqspr_defs.svh"
module tb;
    import irqspr_pkg::*;
    logic        i_sys_clk, i_sys_rst, i_wr, i_rd, o_core_req, o_core_mvec;
    logic [3:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [7:0]  i_src_pend;
    logic [5:0]  o_core_vec, taken_vector;
    logic [2:0]  o_core_prio, taken_level;
    int          err_count, compares, n;
    irqspr_top u_dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_src_pend(i_src_pend), .o_core_req(o_core_req), .o_core_vec(o_core_vec),
        .o_core_prio(o_core_prio), .o_core_mvec(o_core_mvec));
    irqspr_core_model u_core (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
        .i_req(o_core_req), .i_vector(o_core_vec), .i_level(o_core_prio),
        .i_multi(o_core_mvec), .o_taken_vector(taken_vector), .o_taken_level(taken_level));
    // clock at 100 ns
    initial begin
        i_sys_clk = 1'b0;
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd
    task automatic pend(input logic [7:0] p);
        @(posedge i_sys_clk);
        i_src_pend <= p;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask : pend
    task automatic complete_run;
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // reset values, read-only status, unmapped place, full-width reload
    task automatic test_regs;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        wr(4'h0, 32'hffff_ffff);
        rd(4'h0, 32'h0);
        rd(4'h2, 32'h0);
        // write then read back on the very next cycle
        @(posedge i_sys_clk);
        i_addr  <= 4'h4;
        i_wdata <= 32'h1234_5678;
        i_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
        i_rd    <= 1'b1;
        @(posedge i_sys_clk);
        i_rd    <= 1'b0;
        #1 chk(o_rdata, 32'h1234_5678);
        wr(4'h4, 32'hffff_ffff);
        rd(4'h4, 32'hffff_ffff);
        wr(4'h4, 32'h0);
    endtask : test_regs
    // level ordering, tie on lowest index, disabled level, status fields
    task automatic test_arb;
        wr(4'hc, (32'h5 << 3) | (32'h5 << 6) | (32'h3 << 9) | (32'h7 << 18));
        pend(8'h47);
        chk({o_core_req, o_core_prio, o_core_vec}, {1'b1, 3'h7, 6'h06});
        rd(4'h0, 32'h0000_0706);
        chk({taken_level, taken_vector}, {3'h7, 6'h06});
        pend(8'h07);
        rd(4'h0, 32'h0000_0501);
        pend(8'h00);
        chk(o_core_req, 1'b0);
    endtask : test_arb
    // deferral by the proximity timer loaded from the reload register
    task automatic test_timer;
        wr(4'h4, 32'h6);
        wr(4'h8, 32'h2);
        @(posedge i_sys_clk);
        i_src_pend <= 8'h08;
        @(posedge i_sys_clk);
        #1;
        for (n = 0; n < 20 && o_core_req !== 1'b1; n++) begin
            @(posedge i_sys_clk);
            #1;
        end
        chk(n >= 4 && n <= 9, 1'b1);
        rd(4'h0, 32'h0000_0303);
    endtask : test_timer
    // multi-vector delivery follows config two cycles after the write
    task automatic test_mode;
        wr(4'h8, 32'h1);
        repeat (2) @(posedge i_sys_clk);
        #1 chk(o_core_mvec, 1'b1);
        pend(8'h00);
        pend(8'h02);
        chk({o_core_req, o_core_vec}, {1'b1, 6'h01});
        chk({taken_level, taken_vector}, {3'h3, 6'h03});
        rd(4'h0, 32'h0000_0501);
        wr(4'h8, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        #1 chk(o_core_mvec, 1'b0);
    endtask : test_mode
    initial begin
        {i_wr, i_rd, i_addr, i_wdata, i_src_pend} = '0;
        err_count = 0;
        compares  = 0;
        i_sys_rst = 1'b1;
        repeat (3) @(posedge i_sys_clk);
        i_sys_rst <= 1'b0;
        test_regs();
        test_arb();
        test_timer();
        test_mode();
        complete_run();
    end
    // watchdog at 2000 cycles, well beyond the fewer than 100 cycles the tests need
    initial begin
        #200000;
        err_count++;
        complete_run();
    end
endmodule : tb
